// *** sim/dmf_checker_assertions.sv ***
// checker: bus, program counter and dummy cycle relations at the top ports
`timescale 1ns/1ps
module dmf_checker
    import dmf_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        SRST,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // program side
    input wire logic [13:0] TABLE_DATA,
    input wire logic [9:0]  PC_OUT,
    input wire logic        DUMMY_CYCLE
);
    logic [7:0] addr_q;
    logic [7:0] wd_q;
    logic       apb_wr;
    logic       apb_rd;
    logic       pcl_wr;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && PENABLE && !PWRITE;
    // only direct data writes to the low counter byte are tracked here
    assign pcl_wr = apb_wr && PADDR == R_CTRL
                    && PWDATA[3:0] == CMD_WRMEM && addr_q == A_PCL;
    always_ff @(posedge CLK) begin
        if (SRST) addr_q <= ZERO8;
        else if (apb_wr && PADDR == R_ADDR) addr_q <= PWDATA[7:0];
    end
    always_ff @(posedge CLK) begin
        if (SRST) wd_q <= ZERO8;
        else if (apb_wr && PADDR == R_WDATA) wd_q <= PWDATA[7:0];
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_zero_wait: assert property (PSEL && PENABLE |-> PREADY && !PSLVERR)
        else $error("slave stalled or flagged an error");
    a_rdata_idle: assert property (!(PSEL && PENABLE) |-> PRDATA == 32'h0)
        else $error("read data driven outside access phase");
    a_unmapped_zero: assert property (apb_rd && PADDR > R_PTRS |->
        PRDATA == 32'h0) else $error("unmapped read not zero");
    a_status_upper: assert property (apb_rd && PADDR == R_STATUS |->
        PRDATA[31:6] == 26'h0) else $error("status upper bits set");
    a_pcl_dummy: assert property (pcl_wr |=> DUMMY_CYCLE ##1 !DUMMY_CYCLE)
        else $error("dummy cycle missing or too long");
    a_dummy_cause: assert property (DUMMY_CYCLE |-> $past(pcl_wr))
        else $error("dummy cycle without counter write");
    a_pc_low_jump: assert property (pcl_wr |=> PC_OUT[7:0] == $past(wd_q)
        && PC_OUT[9:8] == $past(PC_OUT[9:8])) else $error("jump wrong");
    a_reset_values: assert property ($past(SRST) |-> PC_OUT == 10'h000
        && !DUMMY_CYCLE) else $error("counter not cleared by reset");
endmodule

bind dmf_top dmf_checker dmf_checker_inst (.CLK(CLK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TABLE_DATA(TABLE_DATA), .PC_OUT(PC_OUT), .DUMMY_CYCLE(DUMMY_CYCLE));

// *** sim/dmf_prog_mem.sv ***
// program memory stand-in: table word derived from the program counter
`timescale 1ns/1ps
module dmf_prog_mem (
    // fetch address
    input  wire logic [9:0]  pc,
    // word, upper six bits become the table high byte
    output logic      [13:0] word
);
    assign word = {pc[5:0] ^ 6'h2a, pc[7:0] ^ 8'h3c};
endmodule

// *** sim/dmf_top_tb_top.sv ***
// testbench: drives the apb port and checks memory, flags and counter
`timescale 1ns/1ps
module dmf_top_tb_top;
    import dmf_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } dmf_row_t;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        dummy;
    logic [13:0] tdata;
    logic [9:0]  pc;
    int          error_cnt = 0;
    int          samples_checked = 0;
    dmf_row_t    rows [9] = '{
        '{8'h40, 8'ha5, 8'ha5},
        '{8'h7f, 8'h3c, 8'h3c},
        '{8'h04, 8'hff, 8'h00},
        '{8'h20, 8'hff, 8'h00},
        '{8'h08, 8'hff, 8'h00},
        '{8'h01, 8'h45, 8'h45},
        '{8'h03, 8'h7e, 8'h7e},
        '{8'h0a, 8'hff, 8'h0f},
        '{8'h07, 8'h06, 8'h06}
    };

    dmf_top dmf_top_inst (.CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
        .TABLE_DATA(tdata), .PC_OUT(pc), .DUMMY_CYCLE(dummy));
    dmf_prog_mem dmf_prog_mem_inst (.pc(pc), .word(tdata));

    initial begin
        forever #25 clk = ~clk;
    end

    // one idle edge after each transfer keeps strobes from double drives
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic mem(input logic [3:0] cmd, input logic [7:0] a,
                       input logic [7:0] d, input logic [2:0] b);
        apb(1'b1, R_ADDR, {24'h0, a});
        apb(1'b1, R_WDATA, {24'h0, d});
        apb(1'b1, R_CTRL, {25'h0, b, cmd});
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] exp);
        mem(CMD_RDMEM, a, 8'h00, 3'h0);
        apb(1'b0, R_RDATA, 32'h0);
        chk("byte", {24'h0, exp}, rd);
    endtask
    task automatic apb_chk(input logic [11:0] a, input logic [31:0] msk,
                           input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("reg", exp, rd & msk);
    endtask
    task automatic alu(input logic [3:0] op, input logic [7:0] w,
                       input logic [7:0] m, input logic [7:0] ew,
                       input logic [7:0] es);
        apb(1'b1, R_WORK, {24'h0, w});
        mem(CMD_WRMEM, 8'h43, m, 3'h0);
        apb(1'b1, R_ALU, {28'h0, op});
        mem(CMD_ALU, 8'h43, 8'h00, 3'h0);
        apb_chk(R_WORK, 32'hff, {24'h0, ew});
        apb_chk(R_STATUS, 32'hff, {24'h0, es});
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        error_cnt++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            mem(CMD_WRMEM, rows[i].addr, rows[i].wdata, 3'h0);
            rdm(rows[i].addr, rows[i].rdata);
        end
        apb_chk(R_PTRS, 32'hffffff, 32'h067e45);
        apb_chk(12'h030, 32'hffffffff, 32'h0);
        $display("table rows done");
        mem(CMD_WRMEM, A_PTR0, 8'h41, 3'h0);
        mem(CMD_WRMEM, A_IND0, 8'h77, 3'h0);
        rdm(8'h41, 8'h77);
        mem(CMD_WRMEM, A_PTR1, A_IND0, 3'h0);
        mem(CMD_WRMEM, A_IND1, 8'h99, 3'h0);
        rdm(A_IND1, 8'h00);
        $display("indirect done");
        mem(CMD_WRMEM, 8'h42, 8'h00, 3'h0);
        mem(CMD_BSET, 8'h42, 8'h00, 3'h5);
        rdm(8'h42, 8'h20);
        mem(CMD_WRMEM, 8'h42, 8'hff, 3'h0);
        mem(CMD_BCLR, 8'h42, 8'h00, 3'h0);
        rdm(8'h42, 8'hfe);
        $display("bit ops done");
        alu(OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h0a);
        alu(OP_ADD, 8'h80, 8'h80, 8'h00, 8'h0d);
        alu(OP_SUB, 8'h10, 8'h10, 8'h00, 8'h07);
        alu(OP_ADC, 8'h0f, 8'h10, 8'h20, 8'h02);
        alu(OP_SBC, 8'h10, 8'h01, 8'h0e, 8'h01);
        alu(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h05);
        alu(OP_RRC, 8'h02, 8'h00, 8'h81, 8'h00);
        alu(OP_RLC, 8'h80, 8'h00, 8'h00, 8'h05);
        alu(OP_OR, 8'h50, 8'h0a, 8'h5a, 8'h01);
        alu(OP_XOR, 8'h5a, 8'h5a, 8'h00, 8'h05);
        apb(1'b1, R_WORK, 32'h5c);
        mem(CMD_MOVWM, 8'h44, 8'h00, 3'h0);
        rdm(8'h44, 8'h5c);
        $display("alu done");
        apb(1'b1, R_EVENT, 32'h1);
        apb_chk(R_STATUS, 32'h30, 32'h10);
        apb(1'b1, R_EVENT, 32'h4);
        apb_chk(R_STATUS, 32'h30, 32'h30);
        mem(CMD_WRMEM, A_STATUS, 8'h00, 3'h0);
        apb_chk(R_STATUS, 32'h30, 32'h30);
        apb(1'b1, R_EVENT, 32'h2);
        apb_chk(R_STATUS, 32'h30, 32'h00);
        apb(1'b1, R_EVENT, 32'h3);
        apb_chk(R_STATUS, 32'h30, 32'h10);
        apb(1'b1, R_EVENT, 32'h6);
        apb_chk(R_STATUS, 32'h30, 32'h20);
        $display("system flags done");
        apb(1'b1, R_PC, 32'h300);
        mem(CMD_WRMEM, A_PCL, 8'h5a, 3'h0);
        chk("pc", 32'h35a, {22'h0, pc});
        // word at 35a: high 1a^2a, low 5a^3c
        mem(CMD_TBLRD, 8'h45, 8'h00, 3'h0);
        rdm(8'h45, 8'h66);
        apb_chk(R_TBLHI, 32'hff, 32'h30);
        mem(CMD_WRMEM, A_TBLPTR, 8'hff, 3'h0);
        mem(CMD_INC, A_TBLPTR, 8'h00, 3'h0);
        apb_chk(R_PTRS, 32'hff0000, 32'h000000);
        mem(CMD_DEC, A_TBLPTR, 8'h00, 3'h0);
        mem(CMD_DEC, A_TBLPTR, 8'h00, 3'h0);
        rdm(A_TBLPTR, 8'hfe);
        $display("jump and table done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb_chk(R_STATUS, 32'hff, 32'h00);
        apb_chk(R_PC, 32'h3ff, 32'h000);
        $display("reset done");
        end_of_test;
    end
endmodule

// *** verilog/dmf_pkg.sv ***
// package: data memory and special register file constants and types
package dmf_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_W   = 10;
    // special register addresses
    localparam logic [7:0] A_IND0    = 8'h00;
    localparam logic [7:0] A_PTR0    = 8'h01;
    localparam logic [7:0] A_IND1    = 8'h02;
    localparam logic [7:0] A_PTR1    = 8'h03;
    localparam logic [7:0] A_WORK    = 8'h05;
    localparam logic [7:0] A_PCL     = 8'h06;
    localparam logic [7:0] A_TBLPTR  = 8'h07;
    localparam logic [7:0] A_TBLHI   = 8'h08;
    localparam logic [7:0] A_STATUS  = 8'h0a;
    localparam logic [7:0] A_CTRL    = 8'h0b;
    localparam logic [7:0] GP_BASE   = 8'h40;
    localparam logic [7:0] GP_LAST   = 8'h7f;
    localparam int         GP_DEPTH  = 64;
    // status bit positions
    localparam int ST_C  = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_OV = 3;
    localparam int ST_PD = 4;
    localparam int ST_TO = 5;
    localparam logic [7:0] ST_WR_MASK = 8'h0f;
    localparam logic [7:0] ZERO8      = 8'h00;
    // apb register map
    localparam logic [11:0] R_CTRL   = 12'h000;
    localparam logic [11:0] R_ADDR   = 12'h004;
    localparam logic [11:0] R_WDATA  = 12'h008;
    localparam logic [11:0] R_RDATA  = 12'h00c;
    localparam logic [11:0] R_STATUS = 12'h010;
    localparam logic [11:0] R_WORK   = 12'h014;
    localparam logic [11:0] R_PC     = 12'h018;
    localparam logic [11:0] R_TBLHI  = 12'h01c;
    localparam logic [11:0] R_ALU    = 12'h020;
    localparam logic [11:0] R_EVENT  = 12'h024;
    localparam logic [11:0] R_PTRS   = 12'h028;
    // command codes in R_CTRL[3:0]
    typedef enum logic [3:0] {
        CMD_NONE   = 4'h0,
        CMD_RDMEM  = 4'h1,
        CMD_WRMEM  = 4'h2,
        CMD_BSET   = 4'h3,
        CMD_BCLR   = 4'h4,
        CMD_ALU    = 4'h5,
        CMD_TBLRD  = 4'h6,
        CMD_INC    = 4'h7,
        CMD_DEC    = 4'h8,
        CMD_MOVWM  = 4'h9
    } dmf_cmd_t;
    // alu ops in R_ALU[3:0]
    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_ADC = 4'h1,
        OP_SUB = 4'h2,
        OP_SBC = 4'h3,
        OP_AND = 4'h4,
        OP_OR  = 4'h5,
        OP_XOR = 4'h6,
        OP_RRC = 4'h7,
        OP_RLC = 4'h8
    } dmf_op_t;
    // event bits in R_EVENT
    localparam int EV_HALT = 0;
    localparam int EV_WCLR = 1;
    localparam int EV_WDTO = 2;
endpackage

// *** verilog/dmf_top.sv ***
// data memory and special function register file with apb command port
`timescale 1ns/1ps
module dmf_top
    import dmf_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // table data returned by program memory
    input  wire logic [13:0] TABLE_DATA,
    // program counter to fetch logic
    output logic      [9:0]  PC_OUT,
    output logic             DUMMY_CYCLE
);
    import dmf_pkg::*;

    logic [7:0] gp_mem [GP_DEPTH];
    logic [7:0] ptr0_reg, ptr1_reg, work_reg, tblptr_reg, tblhi_reg;
    logic [7:0] ctrl_reg, addr_reg, wdata_reg, rdata_reg, alu_reg;
    logic [5:0] status_reg;
    logic [9:0] pc_reg;
    logic       dummy_reg;

    logic wr_en, rd_en, go;
    logic [3:0] cmd;
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;
    assign go    = wr_en && PADDR == R_CTRL;
    assign cmd   = PWDATA[3:0];
    // every access completes in its first access cycle, so no wait states
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;

    // resolve indirect ports to the pointer value
    logic [7:0] eff_addr;
    logic       eff_null;
    always_comb begin
        eff_addr = addr_reg;
        if (addr_reg == A_IND0) begin
            eff_addr = ptr0_reg;
        end else if (addr_reg == A_IND1) begin
            eff_addr = ptr1_reg;
        end
        // port pointing at a port has nothing behind it
        eff_null = (eff_addr == A_IND0) || (eff_addr == A_IND1);
    end

    logic [5:0] gp_idx;
    logic       is_gp;
    assign is_gp  = eff_addr >= GP_BASE && eff_addr <= GP_LAST;
    // general area sits on a 64-byte boundary; low address bits index it
    assign gp_idx = eff_addr[5:0] - GP_BASE[5:0];

    // data memory read mux
    logic [7:0] mem_rd;
    always_comb begin
        mem_rd = ZERO8;
        if (!eff_null) begin
            if (is_gp) begin
                mem_rd = gp_mem[gp_idx];
            end else begin
                case (eff_addr)
                    A_PTR0:   mem_rd = ptr0_reg;
                    A_PTR1:   mem_rd = ptr1_reg;
                    A_WORK:   mem_rd = work_reg;
                    A_PCL:    mem_rd = pc_reg[7:0];
                    A_TBLPTR: mem_rd = tblptr_reg;
                    A_TBLHI:  mem_rd = tblhi_reg;
                    A_STATUS: mem_rd = {2'b00, status_reg};
                    default:  mem_rd = ZERO8;
                endcase
            end
        end
    end

    // value written back to memory by each writing command (RDMEM and ALU write none)
    logic [7:0] bit_mask, mem_wval;
    logic       mem_we;
    assign bit_mask = 8'h01 << PWDATA[6:4];
    always_comb begin
        mem_we   = 1'b0;
        mem_wval = wdata_reg;
        if (go) begin
            case (cmd)
                CMD_WRMEM: mem_we = 1'b1;
                CMD_MOVWM: begin
                    mem_we   = 1'b1;
                    mem_wval = work_reg;
                end
                CMD_BSET: begin
                    mem_we   = 1'b1;
                    mem_wval = mem_rd | bit_mask;
                end
                CMD_BCLR: begin
                    mem_we   = 1'b1;
                    mem_wval = mem_rd & ~bit_mask;
                end
                CMD_TBLRD: begin
                    mem_we   = 1'b1;
                    mem_wval = TABLE_DATA[7:0];
                end
                CMD_INC: begin
                    mem_we   = 1'b1;
                    mem_wval = mem_rd + 8'h01;
                end
                CMD_DEC: begin
                    mem_we   = 1'b1;
                    mem_wval = mem_rd - 8'h01;
                end
                default: mem_we = 1'b0;
            endcase
        end
    end

    logic wr_ok;
    assign wr_ok = mem_we && !eff_null;

    // alu: operand b from memory, a from working register
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res, b_op;
    logic       cin, c_new, ac_new, ov_new, arith, rot, c7;
    always_comb begin
        b_op  = mem_rd;
        cin   = 1'b0;
        arith = 1'b1;
        rot   = 1'b0;
        case (alu_reg[3:0])
            OP_ADC: cin = status_reg[ST_C];
            OP_SUB: begin
                b_op = ~mem_rd;
                cin  = 1'b1;
            end
            OP_SBC: begin
                b_op = ~mem_rd;
                cin  = status_reg[ST_C];
            end
            default: cin = 1'b0;
        endcase
        // subtraction as a + ~b + 1: carry out means no borrow
        sum = {1'b0, work_reg} + {1'b0, b_op} + {8'h00, cin};
        nib = {1'b0, work_reg[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
        c7  = work_reg[7] ^ b_op[7] ^ sum[7];
        res = sum[7:0];
        c_new  = sum[8];
        ac_new = nib[4];
        ov_new = c7 ^ sum[8];
        case (alu_reg[3:0])
            OP_AND: begin
                res   = work_reg & mem_rd;
                arith = 1'b0;
            end
            OP_OR: begin
                res   = work_reg | mem_rd;
                arith = 1'b0;
            end
            OP_XOR: begin
                res   = work_reg ^ mem_rd;
                arith = 1'b0;
            end
            OP_RRC: begin
                res   = {status_reg[ST_C], work_reg[7:1]};
                c_new = work_reg[0];
                arith = 1'b0;
                rot   = 1'b1;
            end
            OP_RLC: begin
                res   = {work_reg[6:0], status_reg[ST_C]};
                c_new = work_reg[7];
                arith = 1'b0;
                rot   = 1'b1;
            end
            default: arith = 1'b1;
        endcase
    end

    // general purpose memory
    always_ff @(posedge CLK) begin
        if (wr_ok && is_gp) begin
            gp_mem[gp_idx] <= mem_wval;
        end
    end

    // pointers and table pointer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ptr0_reg   <= ZERO8;
            ptr1_reg   <= ZERO8;
            tblptr_reg <= ZERO8;
        end else if (wr_ok) begin
            if (eff_addr == A_PTR0) ptr0_reg <= mem_wval;
            if (eff_addr == A_PTR1) ptr1_reg <= mem_wval;
            if (eff_addr == A_TBLPTR) tblptr_reg <= mem_wval;
        end
    end

    // working register: alu results and direct moves
    always_ff @(posedge CLK) begin
        if (SRST) begin
            work_reg <= ZERO8;
        end else if (wr_en && PADDR == R_WORK) begin
            work_reg <= PWDATA[7:0];
        end else if (go && cmd == CMD_ALU) begin
            work_reg <= res;
        end else if (go && cmd == CMD_RDMEM) begin
            work_reg <= mem_rd;
        end else if (wr_ok && eff_addr == A_WORK) begin
            work_reg <= mem_wval;
        end
    end

    // table high byte is read only to the program
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tblhi_reg <= ZERO8;
        end else if (go && cmd == CMD_TBLRD) begin
            tblhi_reg <= {2'b00, TABLE_DATA[13:8]};
        end
    end

    // program counter; only the low byte is data memory visible
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pc_reg    <= '0;
            dummy_reg <= 1'b0;
        end else begin
            dummy_reg <= wr_ok && eff_addr == A_PCL;
            if (wr_ok && eff_addr == A_PCL) begin
                pc_reg <= {pc_reg[9:8], mem_wval};
            end else if (wr_en && PADDR == R_PC) begin
                pc_reg <= PWDATA[9:0];
            end
        end
    end
    assign PC_OUT      = pc_reg;
    assign DUMMY_CYCLE = dummy_reg;

    // status flags; never stacked, software saves them itself
    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_reg <= '0;
        end else begin
            if (go && cmd == CMD_ALU) begin
                status_reg[ST_Z] <= res == ZERO8;
                if (arith || rot) status_reg[ST_C] <= c_new;
                if (arith) begin
                    status_reg[ST_AC] <= ac_new;
                    status_reg[ST_OV] <= ov_new;
                end
            end else if (wr_ok && eff_addr == A_STATUS) begin
                // timeout and sleep bits lie outside the write mask
                status_reg <= (status_reg & ~ST_WR_MASK[5:0])
                    | (mem_wval[5:0] & ST_WR_MASK[5:0]);
            end
            if (wr_en && PADDR == R_EVENT) begin
                // a set and a clear in one write: the set wins
                if (PWDATA[EV_HALT]) begin
                    status_reg[ST_PD] <= 1'b1;
                end else if (PWDATA[EV_WCLR]) begin
                    status_reg[ST_PD] <= 1'b0;
                end
                if (PWDATA[EV_WDTO]) begin
                    status_reg[ST_TO] <= 1'b1;
                end else if (PWDATA[EV_WCLR] || PWDATA[EV_HALT]) begin
                    status_reg[ST_TO] <= 1'b0;
                end
            end
        end
    end

    // command registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_reg  <= ZERO8;
            addr_reg  <= ZERO8;
            wdata_reg <= ZERO8;
            alu_reg   <= ZERO8;
            rdata_reg <= ZERO8;
        end else begin
            if (wr_en && PADDR == R_CTRL)  ctrl_reg  <= PWDATA[7:0];
            if (wr_en && PADDR == R_ADDR)  addr_reg  <= PWDATA[7:0];
            if (wr_en && PADDR == R_WDATA) wdata_reg <= PWDATA[7:0];
            if (wr_en && PADDR == R_ALU)   alu_reg   <= PWDATA[7:0];
            if (go && cmd == CMD_RDMEM)    rdata_reg <= mem_rd;
        end
    end

    // apb read data, combinational on the access phase
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (rd_en) begin
            case (PADDR)
                R_CTRL:   PRDATA = {24'h0, ctrl_reg};
                R_ADDR:   PRDATA = {24'h0, addr_reg};
                R_WDATA:  PRDATA = {24'h0, wdata_reg};
                R_RDATA:  PRDATA = {24'h0, rdata_reg};
                R_STATUS: PRDATA = {26'h0, status_reg};
                R_WORK:   PRDATA = {24'h0, work_reg};
                R_PC:     PRDATA = {22'h0, pc_reg};
                R_TBLHI:  PRDATA = {24'h0, tblhi_reg};
                R_ALU:    PRDATA = {24'h0, alu_reg};
                R_PTRS:   PRDATA = {8'h0, tblptr_reg, ptr1_reg, ptr0_reg};
                default:  PRDATA = 32'h0000_0000;
            endcase
        end
    end
endmodule
